/* File: inc/dbcsr_pkg.sv */
// Package: register map, field layout and types of the dual buck command/status bank
package dbcsr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DBCSR_CH1_COMMAND_ADDR = 8'h02;
    localparam logic [7:0] DBCSR_CH2_COMMAND_ADDR = 8'h03;
    localparam logic [7:0] DBCSR_STATUS_ADDR = 8'h04;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int DBCSR_SLEW_LSB = 4;
    localparam int DBCSR_SLEW_MSB = 6;
    localparam int DBCSR_MODE_LSB = 1;
    localparam int DBCSR_MODE_MSB = 2;
    localparam int DBCSR_OFF_BIT = 0;
    localparam int DBCSR_HOT_BIT = 2;
    localparam int DBCSR_PG2_BIT = 1;
    localparam int DBCSR_PG1_BIT = 0;
    localparam logic [7:0] DBCSR_COMMAND_RESET = 8'h00;
    localparam logic [7:0] DBCSR_STATUS_RESET = 8'h00;
    localparam logic [6:0] DBCSR_TARGET_RESET = 7'h00;
    localparam logic [7:0] DBCSR_COMMAND_WMASK = 8'h77;
    localparam logic [7:0] DBCSR_STATUS_RMASK = 8'h07;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] DBCSR_MODE_PIN = 2'h0;
    localparam logic [1:0] DBCSR_MODE_FIXED = 2'h1;
    localparam logic [1:0] DBCSR_MODE_SKIP = 2'h2;
    localparam logic [7:0] DBCSR_SLEW_CNT_RESET = 8'h00;

    typedef enum logic [1:0] {
        DBCSR_OP_FIXED = 2'h1,
        DBCSR_OP_SKIP = 2'h2
    } dbcsr_op_type;

    typedef struct packed {
        logic [2:0] slew;
        logic [1:0] mode;
        logic output_off;
    } dbcsr_chan_cfg_type;

    typedef struct packed {
        logic wr_strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } dbcsr_wr_type;

    typedef struct packed {
        logic over_temp;
        logic ch2_ok;
        logic ch1_ok;
    } dbcsr_status_type;

endpackage

/* File: design/dbcsr_slew_stepper.sv */
// Per-channel 10 mV stepper that walks the live code toward the target code
`timescale 1ns/100ps
module dbcsr_slew_stepper (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sw_cycle,
    input wire logic [2:0] slew,
    input wire logic [6:0] target_code,
    output logic [6:0] live_code
);

    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [6:0] next_live_code;
    logic [7:0] period;

    // ------------------------------------------------------------
    // Pacing: one step per 2**slew switching cycles
    // ------------------------------------------------------------
    always_comb begin
        period = 8'h01 << slew;
        next_cnt = cnt;
        next_live_code = live_code;
        if (live_code == target_code) begin
            next_cnt = dbcsr_pkg::DBCSR_SLEW_CNT_RESET;
        end else if (sw_cycle) begin
            if (cnt + 8'h01 >= period) begin
                next_cnt = dbcsr_pkg::DBCSR_SLEW_CNT_RESET;
                next_live_code = (live_code < target_code) ? live_code + 7'h01 : live_code - 7'h01;
            end else begin
                next_cnt = cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= dbcsr_pkg::DBCSR_SLEW_CNT_RESET;
            live_code <= dbcsr_pkg::DBCSR_TARGET_RESET;
        end else begin
            cnt <= next_cnt;
            live_code <= next_live_code;
        end
    end

endmodule

/* File: design/dbcsr_regs.sv */
// Command and status register bank of the dual buck regulator controller
// Operation
// - Command bits 6..4 pick a step of 10 mV every 1,2,4,...,128 switching cycles for codes 000..111.
// - Mode field 00 hands the channel's mode to the external mode pin.
// - Mode 01 forces fixed frequency, 10 selects pulse skipping, 11 is reserved and must not be written.
// - Command bit 0 set disables the channel output, clear keeps it enabled, reset value 0.
// - Status bit 2 reads 1 while the die is over temperature.
// - Status bit 1 reads 1 while channel 2 is in its power-good window.
// - Status bit 0 reads 1 while channel 1 is in its power-good window.
// - With both hardware enable pins low no bus update is taken; software disables leave the bus working.
// - The 7-bit target code sets 0.68 V to 1.95 V in 10 mV steps, approached at the slew pace.
`timescale 1ns/100ps
module dbcsr_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire dbcsr_pkg::dbcsr_wr_type bus_wr,
    input wire logic [7:0] bus_rd_addr,
    output logic [7:0] bus_rd_data,
    input wire logic channel1_hw_enable_pin,
    input wire logic channel2_hw_enable_pin,
    input wire logic mode_select_pin,
    input wire dbcsr_pkg::dbcsr_status_type status_in,
    input wire logic sw_cycle,
    input wire logic [6:0] channel1_target_code,
    input wire logic [6:0] channel2_target_code,
    output logic [6:0] channel1_live_code,
    output logic [6:0] channel2_live_code,
    output dbcsr_pkg::dbcsr_op_type channel1_op_mode,
    output dbcsr_pkg::dbcsr_op_type channel2_op_mode,
    output logic channel1_output_off,
    output logic channel2_output_off
);

    logic [7:0] channel1_command;
    logic [7:0] channel2_command;
    logic [7:0] system_status;
    logic [7:0] next_channel1_command;
    logic [7:0] next_channel2_command;
    logic [7:0] next_system_status;
    logic [7:0] next_bus_rd_data;
    dbcsr_pkg::dbcsr_op_type next_ch1_op;
    dbcsr_pkg::dbcsr_op_type next_ch2_op;
    dbcsr_pkg::dbcsr_chan_cfg_type cfg1;
    dbcsr_pkg::dbcsr_chan_cfg_type cfg2;
    logic wr_ok;
    logic [6:0] live1_raw;
    logic [6:0] live2_raw;
    logic wr_ch1_hit;
    logic wr_ch2_hit;
    logic next_channel1_output_off;
    logic next_channel2_output_off;
    logic [6:0] next_channel1_live_code;
    logic [6:0] next_channel2_live_code;

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    // The serial engine delivers one strobe per completed address+data pair
    always_comb begin
        // Either enable pin high keeps the bank writable; only a full hardware shutdown locks it
        wr_ok = bus_wr.wr_strobe && (channel1_hw_enable_pin || channel2_hw_enable_pin);
        wr_ch1_hit = wr_ok && (bus_wr.addr == dbcsr_pkg::DBCSR_CH1_COMMAND_ADDR);
        wr_ch2_hit = wr_ok && (bus_wr.addr == dbcsr_pkg::DBCSR_CH2_COMMAND_ADDR);
        next_channel1_command = channel1_command;
        next_channel2_command = channel2_command;
        if (wr_ch1_hit) begin
            next_channel1_command = bus_wr.data & dbcsr_pkg::DBCSR_COMMAND_WMASK;
        end
        if (wr_ch2_hit) begin
            next_channel2_command = bus_wr.data & dbcsr_pkg::DBCSR_COMMAND_WMASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            channel1_command <= dbcsr_pkg::DBCSR_COMMAND_RESET;
            channel2_command <= dbcsr_pkg::DBCSR_COMMAND_RESET;
        end else begin
            channel1_command <= next_channel1_command;
            channel2_command <= next_channel2_command;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    always_comb begin
        cfg1.slew = channel1_command[dbcsr_pkg::DBCSR_SLEW_MSB:dbcsr_pkg::DBCSR_SLEW_LSB];
        cfg1.mode = channel1_command[dbcsr_pkg::DBCSR_MODE_MSB:dbcsr_pkg::DBCSR_MODE_LSB];
        cfg1.output_off = channel1_command[dbcsr_pkg::DBCSR_OFF_BIT];
        cfg2.slew = channel2_command[dbcsr_pkg::DBCSR_SLEW_MSB:dbcsr_pkg::DBCSR_SLEW_LSB];
        cfg2.mode = channel2_command[dbcsr_pkg::DBCSR_MODE_MSB:dbcsr_pkg::DBCSR_MODE_LSB];
        cfg2.output_off = channel2_command[dbcsr_pkg::DBCSR_OFF_BIT];
    end

    // Code 11 is not expected; it falls back to fixed frequency as the safe choice
    function automatic dbcsr_pkg::dbcsr_op_type dbcsr_pick_mode(input logic [1:0] field, input logic pin);
        dbcsr_pkg::dbcsr_op_type r;
        r = dbcsr_pkg::DBCSR_OP_FIXED;
        unique case (field)
            dbcsr_pkg::DBCSR_MODE_PIN: begin
                r = pin ? dbcsr_pkg::DBCSR_OP_SKIP : dbcsr_pkg::DBCSR_OP_FIXED;
            end
            dbcsr_pkg::DBCSR_MODE_FIXED: begin
                r = dbcsr_pkg::DBCSR_OP_FIXED;
            end
            dbcsr_pkg::DBCSR_MODE_SKIP: begin
                r = dbcsr_pkg::DBCSR_OP_SKIP;
            end
            default: begin
                r = dbcsr_pkg::DBCSR_OP_FIXED;
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Status capture
    // ------------------------------------------------------------
    // One snapshot of all three status bits per clock keeps a read coherent
    always_comb begin
        next_system_status = dbcsr_pkg::DBCSR_STATUS_RESET;
        next_system_status[dbcsr_pkg::DBCSR_HOT_BIT] = status_in.over_temp;
        next_system_status[dbcsr_pkg::DBCSR_PG2_BIT] = status_in.ch2_ok;
        next_system_status[dbcsr_pkg::DBCSR_PG1_BIT] = status_in.ch1_ok;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            system_status <= dbcsr_pkg::DBCSR_STATUS_RESET;
        end else begin
            system_status <= next_system_status;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Addresses without a register in this bank read as zero
    always_comb begin
        unique case (bus_rd_addr)
            dbcsr_pkg::DBCSR_CH1_COMMAND_ADDR: next_bus_rd_data = channel1_command;
            dbcsr_pkg::DBCSR_CH2_COMMAND_ADDR: next_bus_rd_data = channel2_command;
            dbcsr_pkg::DBCSR_STATUS_ADDR: next_bus_rd_data = system_status & dbcsr_pkg::DBCSR_STATUS_RMASK;
            default: next_bus_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rd_data <= 8'h00;
        end else begin
            bus_rd_data <= next_bus_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Channel 1 outputs
    // ------------------------------------------------------------
    // Each output leaves from a flop here, one cycle after the command register or, for the live code, after the stepper
    always_comb begin
        next_ch1_op = dbcsr_pick_mode(cfg1.mode, mode_select_pin);
        next_channel1_output_off = cfg1.output_off;
        next_channel1_live_code = live1_raw;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            channel1_op_mode <= dbcsr_pkg::DBCSR_OP_FIXED;
            channel1_output_off <= 1'h0;
            channel1_live_code <= dbcsr_pkg::DBCSR_TARGET_RESET;
        end else begin
            channel1_op_mode <= next_ch1_op;
            channel1_output_off <= next_channel1_output_off;
            channel1_live_code <= next_channel1_live_code;
        end
    end

    // ------------------------------------------------------------
    // Channel 2 outputs
    // ------------------------------------------------------------
    always_comb begin
        next_ch2_op = dbcsr_pick_mode(cfg2.mode, mode_select_pin);
        next_channel2_output_off = cfg2.output_off;
        next_channel2_live_code = live2_raw;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            channel2_op_mode <= dbcsr_pkg::DBCSR_OP_FIXED;
            channel2_output_off <= 1'h0;
            channel2_live_code <= dbcsr_pkg::DBCSR_TARGET_RESET;
        end else begin
            channel2_op_mode <= next_ch2_op;
            channel2_output_off <= next_channel2_output_off;
            channel2_live_code <= next_channel2_live_code;
        end
    end

    // ------------------------------------------------------------
    // Slew pacing toward each target
    // ------------------------------------------------------------
    dbcsr_slew_stepper u_step1 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sw_cycle(sw_cycle),
        .slew(cfg1.slew),
        .target_code(channel1_target_code),
        .live_code(live1_raw)
    );

    dbcsr_slew_stepper u_step2 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sw_cycle(sw_cycle),
        .slew(cfg2.slew),
        .target_code(channel2_target_code),
        .live_code(live2_raw)
    );

endmodule

/* File: verif/dbcsr_chk.sv */
// Assertion checker for the command and status register bank
`timescale 1ns/100ps
module dbcsr_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire dbcsr_pkg::dbcsr_wr_type bus_wr,
    input wire logic [7:0] bus_rd_addr,
    input wire logic [7:0] bus_rd_data,
    input wire logic channel1_hw_enable_pin,
    input wire logic channel2_hw_enable_pin,
    input wire logic mode_select_pin,
    input wire dbcsr_pkg::dbcsr_status_type status_in,
    input wire logic [6:0] channel1_live_code,
    input wire dbcsr_pkg::dbcsr_op_type channel1_op_mode,
    input wire logic channel1_output_off,
    input wire logic channel2_output_off
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic en;
    logic wr1;
    assign en = channel1_hw_enable_pin | channel2_hw_enable_pin;
    assign wr1 = bus_wr.wr_strobe && en && bus_wr.addr == 8'h02;
    a_off1_write: assert property (wr1 |=> ##1
        channel1_output_off == $past(bus_wr.data[0], 2)) else $error("channel 1 off bit wrong");
    a_off2_write: assert property (bus_wr.wr_strobe && en && bus_wr.addr == 8'h03 |=> ##1
        channel2_output_off == $past(bus_wr.data[0], 2)) else $error("channel 2 off bit wrong");
    // A write one cycle earlier may still land, so only isolated strobes are judged
    a_hw_block: assert property (bus_wr.wr_strobe && !en && !$past(bus_wr.wr_strobe) |=> ##1
        $stable(channel1_output_off) && $stable(channel2_output_off)) else $error("write taken while off");
    a_mode_reg: assert property (wr1 && ^bus_wr.data[2:1] |=> ##1
        channel1_op_mode == $past(bus_wr.data[2:1], 2)) else $error("mode field not applied");
    a_mode_pin: assert property (wr1 && bus_wr.data[2:1] == 2'h0 ##1 $stable(mode_select_pin) [*2] |->
        channel1_op_mode == (mode_select_pin ? 2'h2 : 2'h1)) else $error("pin mode not followed");
    a_status_read: assert property ((bus_rd_addr == 8'h04) [*3] |->
        bus_rd_data == {5'h00, $past(status_in, 2)}) else $error("status read wrong");
    a_rsv_zero: assert property ((bus_rd_addr inside {8'h02, 8'h03}) [*2] |->
        (bus_rd_data & 8'h88) == 8'h00) else $error("reserved bits not zero");
    a_live_step: assert property (channel1_live_code != $past(channel1_live_code) |->
        channel1_live_code - $past(channel1_live_code) inside {7'h01, 7'h7F}) else $error("live step not one");
endmodule
bind dbcsr_regs dbcsr_chk u_chk (.*);

/* File: verif/dbcsr_host_model.sv */
// Host side model that hands register writes to the bank
`timescale 1ns/100ps
module dbcsr_host_model (
    input wire logic sys_clk,
    output dbcsr_pkg::dbcsr_wr_type bus_wr
);
    initial bus_wr = '0;
    // One byte per strobe; mode code 11 is never sent
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        bus_wr = '{1'b1, addr, data};
        @(negedge sys_clk);
        bus_wr = '{1'b0, ~addr, ~data};
    endtask
endmodule

/* File: verif/dbcsr_regs_tb_top.sv */
// Self-checking testbench of the command and status register bank
`timescale 1ns/100ps
module dbcsr_regs_tb_top;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    dbcsr_pkg::dbcsr_wr_type bus_wr;
    logic [7:0] bus_rd_addr = 8'h00;
    logic [7:0] bus_rd_data;
    logic channel1_hw_enable_pin = 1'b1;
    logic channel2_hw_enable_pin = 1'b1;
    logic mode_select_pin = 1'b0;
    dbcsr_pkg::dbcsr_status_type status_in = 3'h0;
    logic sw_cycle = 1'b0;
    logic [6:0] channel1_target_code = 7'h00;
    logic [6:0] channel2_target_code = 7'h00;
    logic [6:0] channel1_live_code, channel2_live_code;
    dbcsr_pkg::dbcsr_op_type channel1_op_mode, channel2_op_mode;
    logic channel1_output_off, channel2_output_off;
    int mismatches = 0;
    int compares = 0;
    always #25 sys_clk = ~sys_clk;
    dbcsr_regs u_dbcsr_regs (.*);
    dbcsr_host_model u_dbcsr_host_model (.sys_clk(sys_clk), .bus_wr(bus_wr));
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge sys_clk);
        bus_rd_addr = addr;
        repeat (2) @(negedge sys_clk);
        chk(bus_rd_data, exp);
    endtask
    task automatic do_reset(input int n);
        @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (n) @(negedge sys_clk);
        rst_b = 1'b1;
    endtask
    task automatic t_reset;
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        chk({6'h00, channel1_output_off, channel2_output_off}, 8'h00);
        chk({6'h00, channel1_op_mode}, 8'h01);
    endtask
    task automatic t_cmd;
        u_dbcsr_host_model.write(8'h02, 8'hF9);
        u_dbcsr_host_model.write(8'h03, 8'h5B);
        rd(8'h02, 8'h71);
        rd(8'h03, 8'h53);
        chk({6'h00, channel1_output_off, channel2_output_off}, 8'h03);
        chk({6'h00, channel2_op_mode}, 8'h01);
        // Mode codes 00, 01 and 10, each with the pin low then high
        for (int i = 0; i < 6; i++) begin
            @(negedge sys_clk);
            mode_select_pin = i[0];
            u_dbcsr_host_model.write(8'h02, {5'h00, i[2:1], 1'b0});
            repeat (2) @(negedge sys_clk);
            chk({6'h00, channel1_op_mode}, (i < 2) ? 8'(i + 1) : {6'h00, i[2:1]});
        end
        chk({6'h00, channel1_output_off, channel2_output_off}, 8'h01);
    endtask
    task automatic t_hwoff;
        channel1_hw_enable_pin = 1'b0;
        channel2_hw_enable_pin = 1'b0;
        u_dbcsr_host_model.write(8'h03, 8'h00);
        rd(8'h03, 8'h53);
        channel2_hw_enable_pin = 1'b1;
        u_dbcsr_host_model.write(8'h03, 8'h21);
        rd(8'h03, 8'h21);
        chk({6'h00, channel2_op_mode}, 8'h02);
        channel1_hw_enable_pin = 1'b1;
    endtask
    task automatic t_status;
        for (int i = 0; i < 8; i++) begin
            status_in = 3'(i);
            rd(8'h04, 8'(i));
        end
        u_dbcsr_host_model.write(8'h04, 8'hFF);
        rd(8'h04, 8'h07);
        rd(8'h20, 8'h00);
    endtask
    task automatic t_slew;
        int n;
        for (int s = 0; s < 8; s++) begin
            do_reset(2);
            u_dbcsr_host_model.write(8'h02, {1'b0, 3'(s), 4'h0});
            channel1_target_code = 7'h01;
            channel2_target_code = 7'h7F;
            n = 0;
            while (channel1_live_code === 7'h00 && n < 300) begin
                @(negedge sys_clk);
                sw_cycle = 1'b1;
                @(negedge sys_clk);
                sw_cycle = 1'b0;
                repeat (2) @(negedge sys_clk);
                n++;
            end
            if (n >= 300) begin
                mismatches++;
                final_report();
            end
            chk(8'(n), 8'(1 << s));
            chk({1'b0, channel1_live_code}, 8'h01);
            chk({1'b0, channel2_live_code}, (s < 7) ? 8'(1 << s) : 8'h7F);
            channel1_target_code = 7'h00;
            channel2_target_code = 7'h00;
        end
    endtask
    initial begin
        do_reset(16);
        t_reset();
        t_cmd();
        t_hwoff();
        t_status();
        t_slew();
        final_report();
    end
endmodule
